// file: pattern_controller.sv
// Timing pattern output controller with an AXI4-Lite register slave.
// Function
// RL1: Bits 1:0 of trigger select pick timer channel for group 0.
// RL2: Bits 3:2 of trigger select pick timer channel for group 1 (pins 7-4).
// RL3: Bits 5:4 of trigger select pick timer channel for group 2 (pins 11-8).
// RL4: Bits 7:6 of trigger select pick timer channel for group 3 (pins 15-12).
// RL5: Mode bit per group: 0 normal on match A, 1 non-overlapping A/B.
// RL6: Upper enable bits gate pattern bits 15-8 onto port B.
// RL7: Lower enable bits gate pattern bits 7-0 onto port A.
// RL8: Groups 2,3 sharing trigger: all upper data at main address, alt reads ones.
// RL9: Separate triggers: group 3 upper nibble main, group 2 lower nibble alt.
// RL10: Groups 0,1 sharing trigger: all lower data at main address, alt reads ones.
// RL11: Separate triggers: group 1 upper nibble main, group 0 lower nibble alt.
// RL12: Group 0 trigger updates only pins 3-0.
// RL13: Group 2 trigger updates only pins 11-8.
// RL14: Trigger copies data to enabled pin latches at once; disabled pins hold.
// RL15: Reserved bits read as one and ignore writes.
// RL16: Non-overlap: falling pins at match A, rising pins at match B.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pattern_controller (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [pattern_controller_pkg::REG_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pattern_controller_pkg::DATA_W-1:0] wdata,
  input wire logic [pattern_controller_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pattern_controller_pkg::REG_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [pattern_controller_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer unit compare matches, one-cycle pulses per channel
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchA,
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchB,
  // Port pins
  output logic [pattern_controller_pkg::BYTE_W-1:0] portAOut,
  output logic [pattern_controller_pkg::BYTE_W-1:0] portAOe,
  output logic [pattern_controller_pkg::BYTE_W-1:0] portBOut,
  output logic [pattern_controller_pkg::BYTE_W-1:0] portBOe
);
  import pattern_controller_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic awPend;
    logic [REG_ADDR_W-1:0] awAddr;
    logic wPend;
    logic [DATA_W-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic [GROUPS-1:0] mode;
    logic [BYTE_W-1:0] trigSel;
    logic [BYTE_W-1:0] upperEnable;
    logic [BYTE_W-1:0] lowerEnable;
    logic [PINS-1:0] nextPattern;
  } ctrl_state_type;

  ctrl_state_type q;
  ctrl_state_type d;

  logic upperShared;
  logic lowerShared;
  logic [PINS-1:0] pinEnable;
  logic [PINS-1:0] pattern;
  logic [GROUPS-1:0] groupMatchA;
  logic [GROUPS-1:0] groupMatchB;

  // ----------------------------------------------------------------------------
  // Trigger sharing
  // ----------------------------------------------------------------------------
  // Pairs are compared on their select fields; the register layout follows at once when they change.
  assign upperShared = (q.trigSel[3*SEL_W +: SEL_W] == q.trigSel[2*SEL_W +: SEL_W]); // [RL8] [RL9]
  assign lowerShared = (q.trigSel[1*SEL_W +: SEL_W] == q.trigSel[0*SEL_W +: SEL_W]); // [RL10] [RL11]
  assign pinEnable = {q.upperEnable, q.lowerEnable};

  // ----------------------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------------------
  function automatic logic [BYTE_W-1:0] read_byte(
    input logic [IDX_W-1:0] idx,
    input ctrl_state_type s,
    input logic upShared,
    input logic loShared
  );
    logic [BYTE_W-1:0] v;
    v = '0;
    unique case (idx)
      IDX_MODE: v = {NIBBLE_ONES, s.mode}; // [RL15]
      IDX_TRIG: v = s.trigSel;
      IDX_UPPER_EN: v = s.upperEnable;
      IDX_LOWER_EN: v = s.lowerEnable;
      IDX_UPPER_MAIN: begin
        // [RL8] [RL9] [RL15]
        v = upShared ? s.nextPattern[PINS-1:BYTE_W] : {s.nextPattern[PINS-1 -: GROUP_W], NIBBLE_ONES};
      end
      IDX_UPPER_ALT: begin
        v = upShared ? BYTE_ONES : {NIBBLE_ONES, s.nextPattern[2*GROUP_W +: GROUP_W]}; // [RL8] [RL9] [RL15]
      end
      IDX_LOWER_MAIN: begin
        // [RL10] [RL11] [RL15]
        v = loShared ? s.nextPattern[BYTE_W-1:0] : {s.nextPattern[GROUP_W +: GROUP_W], NIBBLE_ONES};
      end
      IDX_LOWER_ALT: begin
        v = loShared ? BYTE_ONES : {NIBBLE_ONES, s.nextPattern[0 +: GROUP_W]}; // [RL10] [RL11] [RL15]
      end
      default: v = '0;
    endcase
    return v;
  endfunction : read_byte

  function automatic logic index_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_MODE) || (idx == IDX_TRIG) || (idx == IDX_UPPER_EN) || (idx == IDX_LOWER_EN) ||
           (idx == IDX_UPPER_MAIN) || (idx == IDX_LOWER_MAIN) || (idx == IDX_UPPER_ALT) ||
           (idx == IDX_LOWER_ALT);
  endfunction : index_mapped

  // ----------------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------------
  // One write and one read are held at a time; a new address waits until the response has gone.
  // Readies drop while the clock enable is low, since a beat offered then would not be stored.
  // Responses are not masked, so a master must not take bvalid or rvalid while the enable is low.
  assign awready = ce && !q.awPend && !q.bValid;
  assign wready = ce && !q.wPend && !q.bValid;
  assign arready = ce && !q.rValid;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [IDX_W-1:0] wIdx;
    logic [IDX_W-1:0] rIdx;
    logic [BYTE_W-1:0] wb;
    wIdx = q.awAddr[IDX_LSB +: IDX_W];
    rIdx = araddr[IDX_LSB +: IDX_W];
    wb = q.wData[BYTE_W-1:0];
    d = q;

    if (awvalid && awready) begin
      d.awPend = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      d.wPend = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end

    // The write takes effect the cycle after both halves are held.
    if (q.awPend && q.wPend) begin
      d.awPend = 1'b0;
      d.wPend = 1'b0;
      d.bValid = 1'b1;
      d.bResp = index_mapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
      if (q.wStrb[0]) begin
        unique case (wIdx)
          IDX_MODE: d.mode = wb[GROUPS-1:0]; // [RL5] [RL15]
          IDX_TRIG: d.trigSel = wb; // [RL1] [RL2] [RL3] [RL4]
          IDX_UPPER_EN: d.upperEnable = wb; // [RL6]
          IDX_LOWER_EN: d.lowerEnable = wb; // [RL7]
          IDX_UPPER_MAIN: begin
            if (upperShared) begin
              d.nextPattern[PINS-1:BYTE_W] = wb; // [RL8]
            end else begin
              d.nextPattern[3*GROUP_W +: GROUP_W] = wb[BYTE_W-1 -: GROUP_W]; // [RL9] [RL15]
            end
          end
          IDX_UPPER_ALT: begin
            if (!upperShared) begin
              d.nextPattern[2*GROUP_W +: GROUP_W] = wb[GROUP_W-1:0]; // [RL9] [RL15]
            end
          end
          IDX_LOWER_MAIN: begin
            if (lowerShared) begin
              d.nextPattern[BYTE_W-1:0] = wb; // [RL10]
            end else begin
              d.nextPattern[1*GROUP_W +: GROUP_W] = wb[BYTE_W-1 -: GROUP_W]; // [RL11] [RL15]
            end
          end
          IDX_LOWER_ALT: begin
            if (!lowerShared) begin
              d.nextPattern[0 +: GROUP_W] = wb[GROUP_W-1:0]; // [RL11] [RL15]
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end

    if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rValid = 1'b1;
      d.rData = {{(DATA_W-BYTE_W){1'b0}}, read_byte(rIdx, q, upperShared, lowerShared)};
      d.rResp = index_mapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q.awPend <= 1'b0;
      q.awAddr <= '0;
      q.wPend <= 1'b0;
      q.wData <= DATA_ZERO;
      q.wStrb <= '0;
      q.bValid <= 1'b0;
      q.bResp <= RESP_OKAY;
      q.rValid <= 1'b0;
      q.rData <= DATA_ZERO;
      q.rResp <= RESP_OKAY;
      q.mode <= MODE_RST;
      q.trigSel <= TRIG_RST;
      q.upperEnable <= ENABLE_RST;
      q.lowerEnable <= ENABLE_RST;
      q.nextPattern <= PATTERN_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign bvalid = q.bValid;
  assign bresp = q.bResp;
  assign rvalid = q.rValid;
  assign rdata = q.rData;
  assign rresp = q.rResp;

  // ----------------------------------------------------------------------------
  // Output groups
  // ----------------------------------------------------------------------------
  // Each group owns its own nibble, so a trigger never disturbs the other groups.
  for (genvar g = 0; g < GROUPS; g++) begin : gen_group
    logic [SEL_W-1:0] sel;
    assign sel = q.trigSel[g*SEL_W +: SEL_W];
    assign groupMatchA[g] = compareMatchA[sel]; // [RL1] [RL2] [RL3] [RL4]
    assign groupMatchB[g] = compareMatchB[sel]; // [RL1] [RL2] [RL3] [RL4]

    pattern_group_latch #(
      .WIDTH(GROUP_W)
    ) u_latch (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .nonOverlap(q.mode[g]), // [RL5]
      .matchA(groupMatchA[g]),
      .matchB(groupMatchB[g]),
      .nextPattern(q.nextPattern[g*GROUP_W +: GROUP_W]), // [RL12] [RL13]
      .pinEnable(pinEnable[g*GROUP_W +: GROUP_W]),
      .pattern(pattern[g*GROUP_W +: GROUP_W]) // [RL14]
    );
  end

  // ----------------------------------------------------------------------------
  // Port pins
  // ----------------------------------------------------------------------------
  assign portAOut = pattern[BYTE_W-1:0]; // [RL7]
  assign portBOut = pattern[PINS-1:BYTE_W]; // [RL6]
  assign portAOe = q.lowerEnable; // [RL7]
  assign portBOe = q.upperEnable; // [RL6]

endmodule : pattern_controller

// file: pattern_controller_pkg.sv
// Shared constants, register indices and reset values of the pattern output controller.
package pattern_controller_pkg;

  // ----------------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------------
  localparam int REG_ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int IDX_LSB = 2;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ----------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MODE = 16'h00A0;
  localparam logic [IDX_W-1:0] IDX_TRIG = 16'h00A1;
  localparam logic [IDX_W-1:0] IDX_UPPER_EN = 16'h00A2;
  localparam logic [IDX_W-1:0] IDX_LOWER_EN = 16'h00A3;
  localparam logic [IDX_W-1:0] IDX_UPPER_MAIN = 16'hFFA4;
  localparam logic [IDX_W-1:0] IDX_LOWER_MAIN = 16'hFFA5;
  localparam logic [IDX_W-1:0] IDX_UPPER_ALT = 16'hFFA6;
  localparam logic [IDX_W-1:0] IDX_LOWER_ALT = 16'hFFA7;

  // ----------------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------------
  localparam int GROUPS = 4;
  localparam int GROUP_W = 4;
  localparam int SEL_W = 2;
  localparam int CHANNELS = 4;
  localparam int PINS = 16;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------------------
  // Reset and fill values
  // ----------------------------------------------------------------------------
  localparam logic [GROUPS-1:0] MODE_RST = 4'h0;
  localparam logic [GROUP_W-1:0] NIBBLE_ONES = 4'hF;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;
  localparam logic [BYTE_W-1:0] TRIG_RST = 8'hFF;
  localparam logic [BYTE_W-1:0] ENABLE_RST = 8'h00;
  localparam logic [PINS-1:0] PATTERN_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

  // ----------------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pattern_controller_pkg

// file: pattern_group_latch.sv
// Output latch of one four-pin pattern group, normal or non-overlapping.
`timescale 1ns/1ps
module pattern_group_latch #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic nonOverlap,
  input wire logic matchA,
  input wire logic matchB,
  input wire logic [WIDTH-1:0] nextPattern,
  input wire logic [WIDTH-1:0] pinEnable,
  output logic [WIDTH-1:0] pattern
);
  import pattern_controller_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] out;
  } latch_state_type;

  latch_state_type q;
  latch_state_type d;
  logic [WIDTH-1:0] falling;
  logic [WIDTH-1:0] rising;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;
    falling = '0;
    rising = '0;
    if (nonOverlap) begin
      // Ones go low at match A and zeros go high at match B, so a pin pair never overlaps. [RL16] [RL5]
      if (matchA) begin
        falling = q.out & ~nextPattern & pinEnable; // [RL6] [RL7]
      end
      if (matchB) begin
        rising = nextPattern & pinEnable; // [RL6] [RL7]
      end
      d.out = (q.out & ~falling) | rising; // [RL14]
    end else if (matchA) begin
      // Disabled pins hold their last level. [RL14] [RL6] [RL7]
      d.out = (q.out & ~pinEnable) | (nextPattern & pinEnable);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pattern = q.out;

endmodule : pattern_group_latch

// file: pattern_controller_props.sv
// Port-level checks of the pattern output controller.
`timescale 1ns/1ps
module pattern_controller_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [pattern_controller_pkg::DATA_W-1:0] rdata,
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchA,
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchB,
  input wire logic [pattern_controller_pkg::BYTE_W-1:0] portAOut,
  input wire logic [pattern_controller_pkg::BYTE_W-1:0] portAOe,
  input wire logic [pattern_controller_pkg::BYTE_W-1:0] portBOut,
  input wire logic [pattern_controller_pkg::BYTE_W-1:0] portBOe
);
  import pattern_controller_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed early");
  chk_r_answer: assert property (ce && arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000)
    else $error("read answer late or wide");
  chk_busy_ready: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answer pending");
  chk_bresp_code: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
    else $error("bad write response code");
  chk_frozen_ready: assert property (!ce |-> !awready && !wready && !arready)
    else $error("bus beat offered while frozen");
  // ----------------------------------------------------------------
  // Pattern pins
  // ----------------------------------------------------------------
  chk_idle_hold: assert property (
    ce && compareMatchA == 4'h0 && compareMatchB == 4'h0 |=> $stable(portAOut) && $stable(portBOut))
    else $error("pins moved without a match");
  chk_pin_gate: assert property (ce |=> ((portAOut ^ $past(portAOut)) & ~$past(portAOe)) == 8'h00
    && ((portBOut ^ $past(portBOut)) & ~$past(portBOe)) == 8'h00)
    else $error("disabled pin changed");
  chk_oe_write: assert property ($changed(portAOe) || $changed(portBOe) |-> $rose(bvalid))
    else $error("pin enable moved without a write");
endmodule : pattern_controller_props
bind pattern_controller pattern_controller_props chk (.core_clk(core_clk), .rst(rst), .ce(ce),
  .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .compareMatchA(compareMatchA), .compareMatchB(compareMatchB), .portAOut(portAOut),
  .portAOe(portAOe), .portBOut(portBOut), .portBOe(portBOe));

// file: timer_match_model.sv
// Timer unit stand-in that issues one-cycle compare-match pulses.
`timescale 1ns/1ps
module timer_match_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] reqA,
  input wire logic [pattern_controller_pkg::CHANNELS-1:0] reqB,
  output logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchA,
  output logic [pattern_controller_pkg::CHANNELS-1:0] compareMatchB
);
  import pattern_controller_pkg::*;
  // A real timer pulses for one cycle per match, so requests are never stretched.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compareMatchA <= '0;
      compareMatchB <= '0;
    end else begin
      compareMatchA <= reqA;
      compareMatchB <= reqB;
    end
  end
endmodule : timer_match_model

// file: test_pattern_controller.sv
// Register and pattern-output bench of the pattern output controller.
`timescale 1ns/1ps
module test_pattern_controller;
  import pattern_controller_pkg::*;
  localparam logic [IDX_W-1:0] RST_IDX [9] = '{IDX_MODE, IDX_TRIG, IDX_UPPER_EN, IDX_LOWER_EN,
    IDX_UPPER_MAIN, IDX_LOWER_MAIN, IDX_UPPER_ALT, IDX_LOWER_ALT, 16'h0001};
  localparam logic [7:0] RST_VAL [9] = '{8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [STRB_W-1:0] wstrb = 4'hF;
  logic [REG_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, ch, oth;
  logic [3:0] reqA = 4'h0, reqB = 4'h0, compareMatchA, compareMatchB;
  logic [7:0] portAOut, portAOe, portBOut, portBOe, pat, prevA, prevB;
  int failures = 0, testsRun = 0;
  always #25 core_clk = ~core_clk;
  pattern_controller dut (.core_clk(core_clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .compareMatchA(compareMatchA), .compareMatchB(compareMatchB), .portAOut(portAOut),
    .portAOe(portAOe), .portBOut(portBOut), .portBOe(portBOe));
  timer_match_model partner (.core_clk(core_clk), .rst(rst), .reqA(reqA), .reqB(reqB),
    .compareMatchA(compareMatchA), .compareMatchB(compareMatchB));
  // ----------------------------------------------------------------
  // Bus and match tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] expv, input logic [31:0] got);
    testsRun++;
    if (got !== expv) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask : cmp
  // Handshakes are sampled mid-cycle, where they equal what the next rising edge sees.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge core_clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (a)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] ev, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'b0;
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v) begin
      @(negedge core_clk);
      a = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (a)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    cmp("rdata", {24'h000000, ev}, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd
  task automatic fire(input logic [3:0] a, input logic [3:0] b, input logic [7:0] ea, input logic [7:0] eb);
    @(posedge core_clk);
    reqA <= a;
    reqB <= b;
    @(posedge core_clk);
    reqA <= 4'h0;
    reqB <= 4'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    cmp("portAOut", {24'h000000, ea}, {24'h000000, portAOut});
    cmp("portBOut", {24'h000000, eb}, {24'h000000, portBOut});
  endtask : fire
  task automatic print_verdict();
    if (failures == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    prevA = 8'h00;
    prevB = 8'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd(RST_IDX[i], RST_VAL[i], (i == 8) ? RESP_SLVERR : RESP_OKAY);
    wr(16'h0001, 8'h55, RESP_SLVERR);
    wr(IDX_MODE, 8'h05, RESP_OKAY);
    rd(IDX_MODE, 8'hF5, RESP_OKAY);
    wr(IDX_MODE, 8'h00, RESP_OKAY);
    // A write without its low byte strobe is answered but leaves the register alone.
    wstrb <= 4'h0;
    wr(IDX_TRIG, 8'h12, RESP_OKAY);
    wstrb <= 4'hF;
    rd(IDX_TRIG, 8'hFF, RESP_OKAY);
    wr(IDX_UPPER_EN, 8'hFF, RESP_OKAY);
    wr(IDX_LOWER_EN, 8'hFF, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      ch = c[1:0];
      oth = ch + 2'd1;
      pat = {2'b00, ch, 2'b01, ch};
      wr(IDX_TRIG, {4{ch}}, RESP_OKAY);
      wr(IDX_UPPER_MAIN, pat, RESP_OKAY);
      wr(IDX_LOWER_MAIN, ~pat, RESP_OKAY);
      fire(4'h1 << oth, 4'h1 << ch, prevA, prevB);
      fire(4'h1 << ch, 4'h0, ~pat, pat);
      prevA = ~pat;
      prevB = pat;
    end
    wr(IDX_TRIG, 8'hE4, RESP_OKAY);
    rd(IDX_UPPER_MAIN, 8'h3F, RESP_OKAY);
    rd(IDX_UPPER_ALT, 8'hF7, RESP_OKAY);
    rd(IDX_LOWER_MAIN, 8'hCF, RESP_OKAY);
    rd(IDX_LOWER_ALT, 8'hF8, RESP_OKAY);
    wr(IDX_UPPER_ALT, 8'h36, RESP_OKAY);
    wr(IDX_UPPER_MAIN, 8'h91, RESP_OKAY);
    wr(IDX_LOWER_ALT, 8'hC3, RESP_OKAY);
    wr(IDX_LOWER_MAIN, 8'h5A, RESP_OKAY);
    fire(4'h1, 4'h0, 8'hC3, 8'h37);
    fire(4'h4, 4'h0, 8'hC3, 8'h36);
    fire(4'hA, 4'h0, 8'h53, 8'h96);
    wr(IDX_LOWER_EN, 8'h0F, RESP_OKAY);
    wr(IDX_UPPER_EN, 8'hF0, RESP_OKAY);
    wr(IDX_TRIG, 8'h00, RESP_OKAY);
    wr(IDX_LOWER_MAIN, 8'hAC, RESP_OKAY);
    wr(IDX_UPPER_MAIN, 8'h21, RESP_OKAY);
    fire(4'h1, 4'h0, 8'h5C, 8'h26);
    cmp("portAOe", 32'h0000000F, {24'h000000, portAOe});
    cmp("portBOe", 32'h000000F0, {24'h000000, portBOe});
    wr(IDX_LOWER_ALT, 8'h00, RESP_OKAY);
    rd(IDX_LOWER_ALT, 8'hFF, RESP_OKAY);
    rd(IDX_LOWER_MAIN, 8'hAC, RESP_OKAY);
    rd(IDX_UPPER_ALT, 8'hFF, RESP_OKAY);
    rd(IDX_UPPER_MAIN, 8'h21, RESP_OKAY);
    wr(IDX_MODE, 8'h01, RESP_OKAY);
    wr(IDX_LOWER_MAIN, 8'hAA, RESP_OKAY);
    fire(4'h1, 4'h0, 8'h58, 8'h26);
    fire(4'h0, 4'h1, 8'h5A, 8'h26);
    wr(IDX_LOWER_MAIN, 8'h55, RESP_OKAY);
    fire(4'h1, 4'h1, 8'h55, 8'h26);
    // With the enable low a trigger must leave every pin where it stands.
    wr(IDX_LOWER_MAIN, 8'hAA, RESP_OKAY);
    ce <= 1'b0;
    fire(4'h1, 4'h1, 8'h55, 8'h26);
    @(posedge core_clk);
    ce <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(IDX_MODE, 8'hF0, RESP_OKAY);
    rd(IDX_LOWER_MAIN, 8'h00, RESP_OKAY);
    cmp("portAOut", 32'h00000000, {24'h000000, portAOut});
    cmp("portAOe", 32'h00000000, {24'h000000, portAOe});
    print_verdict();
  end
endmodule : test_pattern_controller
